// ---- common/dat_defs.svh ----
// Register offsets, reset values and sizing constants of the DMA address tracker
`ifndef DAT_DEFS_SVH
`define DAT_DEFS_SVH

// Register byte offsets
`define DAT_OFS_MEM_SET1 8'h3c
`define DAT_OFS_PCI_SET1 8'h40
`define DAT_OFS_MEM_SET2 8'h48
`define DAT_OFS_PCI_SET2 8'h4c
`define DAT_OFS_WORDS 8'h64
`define DAT_OFS_CUR_MEM 8'h68
`define DAT_OFS_CUR_PCI 8'h6c

// Reset value and address step of one 4-byte word
`define DAT_REG_RESET 32'h0000_0000
`define DAT_ADDR_STEP 32'h0000_0004
`define DAT_WORD_ONE 32'h0000_0001

// Block length: zero in the 20-bit field means one megabyte
`define DAT_LEN_ZERO 20'h0_0000
`define DAT_FULL_MB 21'h10_0000
`define DAT_LEN_ROUND 21'h00_0003
`define DAT_FULL_MB_WORDS 32'h0004_0000

// Byte lane field of an address and the data path sizing
`define DAT_LANE_BITS 1:0
`define DAT_DW 32
`define DAT_FIFO_DEPTH 16
`define DAT_FIFO_AW 4

`endif

// ---- common/dat_pkg.sv ----
// Types shared by the DMA address tracker and its test environment
package dat_pkg;

    // Gray along idle -> run -> drain
    typedef enum logic [1:0]
    {
        DAT_IDLE = 2'h0,
        DAT_RUN = 2'h1,
        DAT_DRAIN = 2'h3
    } dat_state_type;

    // One register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dat_reg_req_type;

    // Controls from the DMA command logic
    typedef struct packed {
        logic start;
        logic set;
        logic [19:0] transfer_byte_length;
        logic pci_inc;
        logic pci_to_mem;
        logic burst_restart;
    } dat_xfer_cfg_type;

    // All state of the top module
    typedef struct packed {
        dat_state_type state;
        logic [1:0][31:0] mem_start;
        logic [1:0][31:0] pci_start;
        logic [31:0] remaining_word_count;
        logic [31:0] feed;
        logic [31:0] cur_mem;
        logic [31:0] cur_pci;
        logic set;
        logic pci_inc;
        logic pci_to_mem;
        logic [1:0] shift;
        logic [31:0] prev;
        logic [31:0] rdata;
        logic busy;
        logic done;
        logic [31:0] mem_wr_data;
        logic mem_wr_valid;
        logic [31:0] pci_wr_data;
        logic pci_wr_valid;
    } dat_top_st_type;

endpackage

// ---- hw/dat_top.sv ----
// DMA address tracking registers, byte aligner and the 16-word DMA FIFO
// Operation
// RQ1: Two writable 32-bit memory start registers at 0x3C and 0x48 reset to zero.
// RQ2: The memory start address never moves; progress lives in the current memory register.
// RQ3: Two writable 32-bit PCI start registers at 0x40 and 0x4C reset to zero.
// RQ4: The PCI start address never moves; progress lives in the current PCI register.
// RQ5: Read-only 0x64 reports the 4-byte words still to move, zero after reset.
// RQ6: Read-only 0x68 shows the local memory address now being accessed, zero after reset.
// RQ7: Read-only 0x6C shows the PCI address now being accessed, zero after reset.
// RQ8: Data moves as bursts both ways even when addresses are unaligned.
// RQ9: Realignment sits between the FIFO and memory in both directions.
// RQ10: Bytes are shifted so FIFO contents carry the PCI side lane alignment.
// RQ11: With increment off a burst restart reloads the PCI start; with it on the address advances.
// RQ12: The 20-bit length is a byte count up to one megabyte, zero meaning a full megabyte.
// RQ13: At start the current registers load the starts and the count loads the length.
// RQ14: The progress registers follow whichever register set runs the transfer.
`timescale 1ns/10ps
`include "dat_defs.svh"

// ****************************************************************
// FIFO
// ****************************************************************
module dat_fifo
#(
    parameter int WIDTH = `DAT_DW,
    parameter int DEPTH = `DAT_FIFO_DEPTH,
    parameter int AW = `DAT_FIFO_AW
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } dat_fifo_st_type;

    dat_fifo_st_type st_r;
    dat_fifo_st_type st_nxt;
    logic push;
    logic pop;

    // Flags come from the stored count, never from the pointers
    assign in_ready = (st_r.count != (AW+1)'(DEPTH));
    assign out_valid = (st_r.count != '0);
    assign out_data = st_r.mem[st_r.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next state
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wptr] = in_data;
            st_nxt.wptr = st_r.wptr + AW'(1);
        end
        if (pop)
        begin
            st_nxt.rptr = st_r.rptr + AW'(1);
        end
        st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= '0;
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
        end
    end
endmodule // dat_fifo

// ****************************************************************
// Top
// ****************************************************************
module dat_top
    import dat_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire dat_reg_req_type reg_req,
    output logic [31:0] reg_rdata,
    input wire dat_xfer_cfg_type xfer_cfg,
    output logic xfer_busy,
    output logic xfer_done,
    input wire logic [31:0] mem_rd_data,
    input wire logic mem_rd_valid,
    output logic mem_rd_ready,
    output logic [31:0] mem_wr_data,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    input wire logic [31:0] pci_rd_data,
    input wire logic pci_rd_valid,
    output logic pci_rd_ready,
    output logic [31:0] pci_wr_data,
    output logic pci_wr_valid,
    input wire logic pci_wr_ready
);
    dat_top_st_type st_r;
    dat_top_st_type st_nxt;
    logic [31:0] fifo_in_data;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [31:0] fifo_out_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic push;
    logic pop;
    logic mem_beat;
    logic pci_beat;
    logic run;

    // Byte shift: lane j of the output takes stream byte j minus shift
    function automatic logic [31:0] align(input logic [31:0] cur, input logic [31:0] prev,
                                          input logic [1:0] sh);
        case (sh)
            2'h1: align = {cur[23:0], prev[31:24]};
            2'h2: align = {cur[15:0], prev[31:16]};
            2'h3: align = {cur[7:0], prev[31:8]};
            default: align = cur;
        endcase
    endfunction

    // Register read decode
    function automatic logic [31:0] reg_read(input logic [7:0] a, input dat_top_st_type s);
        case (a)
            `DAT_OFS_MEM_SET1: reg_read = s.mem_start[0];
            `DAT_OFS_PCI_SET1: reg_read = s.pci_start[0];
            `DAT_OFS_MEM_SET2: reg_read = s.mem_start[1];
            `DAT_OFS_PCI_SET2: reg_read = s.pci_start[1];
            `DAT_OFS_WORDS: reg_read = s.remaining_word_count;
            `DAT_OFS_CUR_MEM: reg_read = s.cur_mem;
            `DAT_OFS_CUR_PCI: reg_read = s.cur_pci;
            default: reg_read = `DAT_REG_RESET;
        endcase
    endfunction

    // Block length in whole words, zero field taken as one megabyte
    function automatic logic [31:0] len_words(input logic [19:0] len);
        logic [20:0] bytes;
        logic [20:0] sum;
        bytes = (len == `DAT_LEN_ZERO) ? `DAT_FULL_MB : {1'b0, len};
        sum = bytes + `DAT_LEN_ROUND;
        len_words = {13'h0000, sum[20:2]};
    endfunction

    // ****************************************************************
    // Data path
    // ****************************************************************
    assign run = (st_r.state == DAT_RUN);

    // Ready gating stays outside the FIFO so back-pressure reaches each source
    assign mem_rd_ready = run && !st_r.pci_to_mem && (st_r.feed != '0) && fifo_in_ready;
    assign pci_rd_ready = run && st_r.pci_to_mem && (st_r.feed != '0) && fifo_in_ready;

    // RQ9 RQ10 aligner at FIFO input
    assign fifo_in_data = st_r.pci_to_mem ? pci_rd_data :
                          align(mem_rd_data, st_r.prev, st_r.shift);
    assign fifo_in_valid = run && (st_r.feed != '0) &&
                           (st_r.pci_to_mem ? pci_rd_valid : mem_rd_valid);
    assign fifo_out_ready = st_r.pci_to_mem ? (!st_r.mem_wr_valid || mem_wr_ready) :
                                              (!st_r.pci_wr_valid || pci_wr_ready);
    assign push = fifo_in_valid && fifo_in_ready;
    assign pop = fifo_out_valid && fifo_out_ready;

    // RQ8 burst beats on either side
    assign mem_beat = st_r.pci_to_mem ? (st_r.mem_wr_valid && mem_wr_ready) : push;
    assign pci_beat = st_r.pci_to_mem ? push : (st_r.pci_wr_valid && pci_wr_ready);

    dat_fifo #(
        .WIDTH(`DAT_DW),
        .DEPTH(`DAT_FIFO_DEPTH),
        .AW(`DAT_FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .in_data(fifo_in_data),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.rdata = `DAT_REG_RESET;
        if (reg_req.rd)
        begin
            st_nxt.rdata = reg_read(reg_req.addr, st_r);
        end
        // RQ1 RQ3 start register writes
        if (reg_req.wr)
        begin
            case (reg_req.addr)
                `DAT_OFS_MEM_SET1: st_nxt.mem_start[0] = reg_req.wdata;
                `DAT_OFS_PCI_SET1: st_nxt.pci_start[0] = reg_req.wdata;
                `DAT_OFS_MEM_SET2: st_nxt.mem_start[1] = reg_req.wdata;
                `DAT_OFS_PCI_SET2: st_nxt.pci_start[1] = reg_req.wdata;
                default: ;
            endcase
        end
        // Output stages drain before refill
        if (st_r.pci_wr_valid && pci_wr_ready)
        begin
            st_nxt.pci_wr_valid = 1'b0;
        end
        if (st_r.mem_wr_valid && mem_wr_ready)
        begin
            st_nxt.mem_wr_valid = 1'b0;
        end
        if (pop && !st_r.pci_to_mem)
        begin
            st_nxt.pci_wr_data = fifo_out_data;
            st_nxt.pci_wr_valid = 1'b1;
        end
        // RQ9 RQ10 aligner at FIFO output toward memory
        if (pop && st_r.pci_to_mem)
        begin
            st_nxt.mem_wr_data = align(fifo_out_data, st_r.prev, st_r.shift);
            st_nxt.mem_wr_valid = 1'b1;
            st_nxt.prev = fifo_out_data;
        end
        if (push && !st_r.pci_to_mem)
        begin
            st_nxt.prev = mem_rd_data;
        end
        if (push)
        begin
            st_nxt.feed = st_r.feed - `DAT_WORD_ONE;
        end
        // RQ2 RQ5 RQ6 memory side progress
        if (mem_beat)
        begin
            st_nxt.remaining_word_count = st_r.remaining_word_count - `DAT_WORD_ONE;
            st_nxt.cur_mem = st_r.cur_mem + `DAT_ADDR_STEP;
        end
        // RQ4 RQ7 RQ11 PCI side progress, restart reload wins
        if (xfer_cfg.burst_restart && !st_r.pci_inc && st_r.state != DAT_IDLE)
        begin
            st_nxt.cur_pci = st_r.pci_start[st_r.set];
        end
        else if (pci_beat)
        begin
            st_nxt.cur_pci = st_r.cur_pci + `DAT_ADDR_STEP;
        end
        case (st_r.state)
            DAT_IDLE:
            begin
                // RQ12 RQ13 RQ14 load from the selected set
                if (xfer_cfg.start)
                begin
                    st_nxt.state = DAT_RUN;
                    st_nxt.busy = 1'b1;
                    st_nxt.set = xfer_cfg.set;
                    st_nxt.pci_inc = xfer_cfg.pci_inc;
                    st_nxt.pci_to_mem = xfer_cfg.pci_to_mem;
                    st_nxt.remaining_word_count = len_words(xfer_cfg.transfer_byte_length);
                    st_nxt.feed = len_words(xfer_cfg.transfer_byte_length);
                    st_nxt.cur_mem = st_r.mem_start[xfer_cfg.set];
                    st_nxt.cur_pci = st_r.pci_start[xfer_cfg.set];
                    st_nxt.prev = `DAT_REG_RESET;
                    st_nxt.shift = xfer_cfg.pci_to_mem ?
                        st_r.mem_start[xfer_cfg.set][`DAT_LANE_BITS] -
                        st_r.pci_start[xfer_cfg.set][`DAT_LANE_BITS] :
                        st_r.pci_start[xfer_cfg.set][`DAT_LANE_BITS] -
                        st_r.mem_start[xfer_cfg.set][`DAT_LANE_BITS];
                end
            end
            DAT_RUN:
            begin
                if (st_nxt.remaining_word_count == '0)
                begin
                    st_nxt.state = DAT_DRAIN;
                end
            end
            DAT_DRAIN:
            begin
                // Waits until the FIFO and both write output stages (PCI and memory) are empty
                if (!fifo_out_valid && !st_nxt.pci_wr_valid && !st_nxt.mem_wr_valid)
                begin
                    st_nxt.state = DAT_IDLE;
                    st_nxt.busy = 1'b0;
                    st_nxt.done = 1'b1;
                end
            end
            default:
            begin
                st_nxt.state = DAT_IDLE;
            end
        endcase
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= '0;
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state
    assign reg_rdata = st_r.rdata;
    assign xfer_busy = st_r.busy;
    assign xfer_done = st_r.done;
    assign mem_wr_data = st_r.mem_wr_data;
    assign mem_wr_valid = st_r.mem_wr_valid;
    assign pci_wr_data = st_r.pci_wr_data;
    assign pci_wr_valid = st_r.pci_wr_valid;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking dat_cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    chk_set2_mem_write: assert property ( // RQ1
        clk_en && reg_req.wr && reg_req.addr == `DAT_OFS_MEM_SET2
        |=> st_r.mem_start[1] == $past(reg_req.wdata))
        else $error("memory start set 2 not written");
    chk_mem_start_static: assert property ( // RQ2
        run && !reg_req.wr |=> $stable(st_r.mem_start))
        else $error("memory start moved during transfer");
    chk_pci_start_static: assert property ( // RQ4
        run && !reg_req.wr |=> $stable(st_r.pci_start))
        else $error("pci start moved during transfer");
    chk_words_read_back: assert property ( // RQ5
        clk_en && reg_req.rd && reg_req.addr == `DAT_OFS_WORDS
        |=> reg_rdata == $past(st_r.remaining_word_count))
        else $error("words read data wrong");
    chk_mem_addr_step: assert property ( // RQ6
        clk_en && mem_beat && st_r.state != DAT_IDLE
        |=> st_r.cur_mem == $past(st_r.cur_mem) + `DAT_ADDR_STEP)
        else $error("current memory address did not step");
    chk_pci_restart_load: assert property ( // RQ11
        clk_en && xfer_cfg.burst_restart && !st_r.pci_inc && st_r.state != DAT_IDLE
        |=> st_r.cur_pci == st_r.pci_start[st_r.set])
        else $error("pci restart did not reload start");
    chk_zero_len_mb: assert property ( // RQ12
        clk_en && st_r.state == DAT_IDLE && xfer_cfg.start &&
        xfer_cfg.transfer_byte_length == `DAT_LEN_ZERO
        |=> st_r.remaining_word_count == `DAT_FULL_MB_WORDS)
        else $error("zero length not one megabyte");
    chk_start_load_set: assert property ( // RQ13
        clk_en && st_r.state == DAT_IDLE && xfer_cfg.start
        |=> st_r.cur_mem == $past(st_r.mem_start[xfer_cfg.set]) && st_r.busy)
        else $error("current memory address not loaded");
    chk_no_overrun: assert property ( // RQ8
        st_r.feed == '0 |-> !mem_rd_ready && !pci_rd_ready)
        else $error("source taken past block end");
    chk_done_pulse: assert property ( // done lasts a single cycle
        clk_en && xfer_done |=> !xfer_done)
        else $error("done longer than a cycle");

    cov_set2_start: cover property (st_r.state == DAT_IDLE && xfer_cfg.start && xfer_cfg.set);
    cov_pci_to_mem: cover property (st_r.pci_to_mem && st_r.mem_wr_valid && mem_wr_ready);
    cov_restart: cover property (run && xfer_cfg.burst_restart && !st_r.pci_inc);
    cov_done: cover property (xfer_done);
endmodule // dat_top

// ---- dv/dat_far_model.sv ----
// Far-side stream partner: memory and PCI data sources and sinks
`timescale 1ns/10ps

// ****************************************************************
// Far side model
// ****************************************************************
module dat_far_model
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic rewind,
    input wire logic src_en,
    input wire logic snk_en,
    output logic [31:0] mem_rd_data,
    output logic mem_rd_valid,
    input wire logic mem_rd_ready,
    output logic mem_wr_ready,
    output logic [31:0] pci_rd_data,
    output logic pci_rd_valid,
    input wire logic pci_rd_ready,
    output logic pci_wr_ready
);
    logic [1:0][31:0] cnt_r; // Word index, 0 = memory, 1 = PCI
    logic [1:0][31:0] last_r;
    logic [1:0] vld_r;
    logic [1:0] snk_r;
    logic [1:0] rdy;

    // Byte n of a stream carries n, so any lane slip shows
    function automatic logic [31:0] pat(input logic [31:0] k);
        logic [7:0] b;
        b = 8'(k << 2);
        return {b + 8'h03, b + 8'h02, b + 8'h01, b};
    endfunction

    assign rdy = {pci_rd_ready, mem_rd_ready};
    // Released lines show the inverse of the last word, never a stale copy
    assign mem_rd_data = vld_r[0] ? pat(cnt_r[0]) : ~last_r[0];
    assign pci_rd_data = vld_r[1] ? pat(cnt_r[1]) : ~last_r[1];
    assign mem_rd_valid = vld_r[0];
    assign pci_rd_valid = vld_r[1];
    assign mem_wr_ready = snk_r[0];
    assign pci_wr_ready = snk_r[1];

    // An offer is held until taken; sinks stall at random
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= '0;
            last_r <= '0;
            vld_r <= '0;
            snk_r <= '0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (vld_r[i] && rdy[i])
                begin
                    cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
                    last_r[i] <= pat(cnt_r[i]);
                end
                if (!vld_r[i] || rdy[i])
                    vld_r[i] <= src_en && ($urandom_range(1, 0) == 1);
                snk_r[i] <= snk_en && ($urandom_range(1, 0) == 1);
                // Offers withdrawn only at start requests; the one made mid-transfer comes with src_en low
                if (rewind)
                begin
                    cnt_r[i] <= '0;
                    vld_r[i] <= 1'b0;
                end
            end
        end
    end
endmodule // dat_far_model

// ---- dv/dat_top_tb_top.sv ----
// Self-checking bench of the DMA address tracker with its far-side partner
`timescale 1ns/10ps
`include "dat_defs.svh"

// ****************************************************************
// Bench top
// ****************************************************************
module dat_top_tb_top
    import dat_pkg::*;
;
    logic mclk, arst_n, clk_en, xfer_busy, xfer_done, rewind, src_en, snk_en, rd_d;
    dat_reg_req_type reg_req;
    dat_xfer_cfg_type xfer_cfg;
    logic [31:0] reg_rdata, mem_rd_data, mem_wr_data, pci_rd_data, pci_wr_data;
    logic mem_rd_valid, mem_rd_ready, mem_wr_valid, mem_wr_ready;
    logic pci_rd_valid, pci_rd_ready, pci_wr_valid, pci_wr_ready;
    logic [31:0] exp_rd[$], exp_mem[$], exp_pci[$];
    logic [31:0] v [4];
    logic [7:0] wofs [4] = '{`DAT_OFS_MEM_SET1, `DAT_OFS_PCI_SET1, `DAT_OFS_MEM_SET2,
                             `DAT_OFS_PCI_SET2};
    logic [7:0] zofs [8] = '{`DAT_OFS_MEM_SET1, `DAT_OFS_PCI_SET1, `DAT_OFS_MEM_SET2,
                             `DAT_OFS_PCI_SET2, `DAT_OFS_WORDS, `DAT_OFS_CUR_MEM,
                             `DAT_OFS_CUR_PCI, 8'h50};
    logic [1:0] lane [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
    int n_fail, compares;

    dat_top i_dat_top (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .xfer_cfg(xfer_cfg), .xfer_busy(xfer_busy),
        .xfer_done(xfer_done), .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid),
        .mem_rd_ready(mem_rd_ready), .mem_wr_data(mem_wr_data), .mem_wr_valid(mem_wr_valid),
        .mem_wr_ready(mem_wr_ready), .pci_rd_data(pci_rd_data), .pci_rd_valid(pci_rd_valid),
        .pci_rd_ready(pci_rd_ready), .pci_wr_data(pci_wr_data), .pci_wr_valid(pci_wr_valid),
        .pci_wr_ready(pci_wr_ready));
    dat_far_model i_dat_far_model (.mclk(mclk), .arst_n(arst_n), .rewind(rewind),
        .src_en(src_en), .snk_en(snk_en), .mem_rd_data(mem_rd_data),
        .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready), .mem_wr_ready(mem_wr_ready),
        .pci_rd_data(pci_rd_data), .pci_rd_valid(pci_rd_valid), .pci_rd_ready(pci_rd_ready),
        .pci_wr_ready(pci_wr_ready));

    // Clock of 10 ns
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        reg_req.wr <= 1'b0;
    endtask

    // The answer is noted here and compared by the monitor a cycle later
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        exp_rd.push_back(e);
        @(posedge mclk);
        reg_req.rd <= 1'b0;
    endtask

    // Stream byte at output lane j of word i is source byte 4i+j-sh
    function automatic logic [31:0] exp_word(input int i, input int sh);
        logic [31:0] w;
        int b;
        w = '0;
        for (int j = 0; j < 4; j++)
        begin
            b = 4 * i + j - sh;
            if (b >= 0)
                w[8*j +: 8] = b[7:0];
        end
        return w;
    endfunction

    task automatic xstart(input logic set, input logic [19:0] len, input logic inc,
                          input logic dir, input logic [1:0] sl, input logic [1:0] dl);
        logic [1:0] sh;
        int n;
        sh = dl - sl;
        n = (len == 20'h0_0000) ? 0 : (int'(len) + 3) / 4;
        @(posedge mclk);
        xfer_cfg <= '{1'b1, set, len, inc, dir, 1'b0};
        rewind <= 1'b1;
        // A start while busy is refused, so it leaves no expected words
        if (xfer_busy === 1'b1)
            n = 0;
        for (int i = 0; i < n; i++)
            if (dir)
                exp_mem.push_back(exp_word(i, int'(sh)));
            else
                exp_pci.push_back(exp_word(i, int'(sh)));
        @(posedge mclk);
        xfer_cfg.start <= 1'b0;
        rewind <= 1'b0;
    endtask

    task automatic wait_done();
        int t;
        t = 0;
        while (xfer_done !== 1'b1 && t < 4000)
        begin
            @(posedge mclk);
            #1;
            t++;
        end
        check("done_seen", 32'(xfer_done), 32'h0000_0001);
        @(posedge mclk);
        #1;
        check("done_pulse", 32'({xfer_done, xfer_busy}), 32'h0000_0000);
    endtask

    task automatic zero_all();
        foreach (zofs[i])
            rd(zofs[i], `DAT_REG_RESET);
    endtask

    // Output monitor: takes the oldest note whenever a result appears
    always @(posedge mclk)
    begin
        if (rd_d)
            check("reg_rdata", reg_rdata, exp_rd.size() ? exp_rd.pop_front() : ~reg_rdata);
        if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1)
            check("mem_wr", mem_wr_data,
                  exp_mem.size() ? exp_mem.pop_front() : ~mem_wr_data);
        if (pci_wr_valid === 1'b1 && pci_wr_ready === 1'b1)
            check("pci_wr", pci_wr_data,
                  exp_pci.size() ? exp_pci.pop_front() : ~pci_wr_data);
        rd_d <= reg_req.rd && arst_n && clk_en;
    end

    // Watchdog well beyond the expected few hundred cycles
    initial
    begin
        #200_000;
        n_fail++;
        finish_test();
    end

    initial
    begin
        void'($urandom(3121));
        {arst_n, rewind, src_en, snk_en, rd_d} = '0;
        clk_en = 1'b1;
        reg_req = '0;
        xfer_cfg = '0;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        zero_all();
        // Start registers take random values; read-only count ignores writes
        foreach (v[i])
        begin
            v[i] = {30'($urandom_range(32'h3fff_ffff, 0)), 2'b00} | 32'(lane[i]);
            wr(wofs[i], v[i]);
        end
        wr(`DAT_OFS_WORDS, $urandom);
        // Clock enable low drops this write; the readback still expects v[2]
        clk_en <= 1'b0;
        wr(`DAT_OFS_MEM_SET2, ~v[2]);
        clk_en <= 1'b1;
        foreach (v[i])
            rd(wofs[i], v[i]);
        rd(`DAT_OFS_WORDS, `DAT_REG_RESET);
        // Set 1, memory to PCI, source held off to see the loaded values
        xstart(1'b0, 20'h0_0010, 1'b1, 1'b0, lane[0], lane[1]);
        #1;
        check("busy", 32'(xfer_busy), 32'h0000_0001);
        xstart(1'b1, 20'h0_0004, 1'b1, 1'b1, 2'h0, 2'h0);
        rd(`DAT_OFS_WORDS, 32'h0000_0004);
        rd(`DAT_OFS_CUR_MEM, v[0]);
        rd(`DAT_OFS_CUR_PCI, v[1]);
        {src_en, snk_en} <= 2'b11;
        wait_done();
        rd(`DAT_OFS_WORDS, 32'h0000_0000);
        rd(`DAT_OFS_CUR_MEM, v[0] + 32'h0000_0010);
        rd(`DAT_OFS_CUR_PCI, v[1] + 32'h0000_0010);
        rd(`DAT_OFS_MEM_SET1, v[0]);
        rd(`DAT_OFS_PCI_SET1, v[1]);
        // Set 2, unaligned 13 bytes both ways: four words on each side
        for (int d = 1; d >= 0; d--)
        begin
            xstart(1'b1, 20'h0_000d, 1'b1, d[0], d ? lane[3] : lane[2], d ? lane[2] : lane[3]);
            wait_done();
            rd(`DAT_OFS_WORDS, 32'h0000_0000);
            rd(`DAT_OFS_CUR_MEM, v[2] + 32'h0000_0010);
            rd(`DAT_OFS_CUR_PCI, v[3] + 32'h0000_0010);
        end
        // Fill the FIFO against a stalled PCI sink, then restart the burst
        xstart(1'b0, 20'h0_0100, 1'b0, 1'b0, lane[0], lane[1]);
        repeat (10) @(posedge mclk);
        snk_en <= 1'b0;
        repeat (100) @(posedge mclk);
        #1;
        check("fifo_full", 32'(mem_rd_ready), 32'h0000_0000);
        @(posedge mclk);
        xfer_cfg.burst_restart <= 1'b1;
        @(posedge mclk);
        xfer_cfg.burst_restart <= 1'b0;
        rd(`DAT_OFS_CUR_PCI, v[1]);
        snk_en <= 1'b1;
        wait_done();
        // Zero length is a full megabyte; reset cuts it short
        src_en <= 1'b0;
        xstart(1'b1, 20'h0_0000, 1'b1, 1'b1, lane[3], lane[2]);
        rd(`DAT_OFS_WORDS, 32'h0004_0000);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        zero_all();
        repeat (2) @(posedge mclk);
        check("leftover", 32'(exp_mem.size() + exp_pci.size() + exp_rd.size()), 0);
        finish_test();
    end
endmodule // dat_top_tb_top
